/* hw/ddi_pkg.sv */
package ddi_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_JOG_REF = 8'h04;
  localparam logic [7:0] OFS_INCH_REF = 8'h08;
  localparam logic [7:0] OFS_FREQ_LIM = 8'h0c;
  localparam logic [7:0] OFS_BRAKE_TIME = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SHAFT = 8'h18;
  localparam logic [7:0] OFS_MOTPOT = 8'h1c;
  // Control register fields
  localparam int CTRL_DECEL_BIT = 0;
  localparam int CTRL_PLACE_LSB = 4;
  localparam int CTRL_SRC_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BRAKE_TIME_RESET = 32'h0000_ffff;
  // Reference source code that routes analogue input one or two
  localparam logic [4:0] SRC_AI_SEL = 5'h0e;
  // Fault codes
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_EXT = 8'h33;
  localparam logic [7:0] FAULT_BRAKE = 8'h3a;
  // Motor potentiometer step period
  localparam int CLK_PERIOD_NS = 5;
  localparam int MP_STEP_NS = 1000;
  localparam int MP_STEP_CYC = MP_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PLACE_IO = 2'b00,
    PLACE_KEYPAD = 2'b01,
    PLACE_FIELDBUS = 2'b10
  } ddi_place_type;

  typedef enum logic [2:0] {
    REF_SRC1 = 3'b000,
    REF_SRC2 = 3'b001,
    REF_AI1 = 3'b010,
    REF_AI2 = 3'b011,
    REF_JOG = 3'b100,
    REF_INCH1 = 3'b101,
    REF_INCH2 = 3'b110
  } ddi_ref_type;

  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_WAIT = 2'b01,
    BRK_DONE = 2'b10
  } ddi_brk_type;

  typedef struct packed {
    logic [2:0] preset;
    logic mp_down;
    logic mp_up;
    logic fault_clear;
    logic ext_fault_no;
    logic ext_fault_nc;
    logic ramp_sel;
    logic ramp_hold;
    logic dc_braking_in;
    logic jog;
    logic ref_select;
    logic force_io;
    logic force_keypad;
    logic force_fieldbus;
    logic parameter_bank_select;
    logic control_mode_select;
    logic brake_ack;
    logic inch_enable;
    logic inch1;
    logic inch2;
    logic second_limit;
    logic pos_reset;
    logic master_follower_alt_in;
  } ddi_din_type;

  typedef struct packed {
    logic running;
    logic start_active;
    logic other_run_req;
    logic ref_below_speed;
    logic brake_open_cmd;
    logic enc_step;
  } ddi_drive_type;
  // Idle contact levels; the normally-closed fault loop rests closed
  localparam ddi_din_type DIN_IDLE = '{ext_fault_nc: 1'b1, default: 1'b0};
endpackage

/* hw/ddi_top.sv */
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module ddi_top
  import ddi_pkg::*;
#(
  parameter int FREQ_W = 16,
  parameter int MP_STEP = MP_STEP_CYC,
  parameter int ANGLE_COUNT = 1024
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Function inputs and drive state
  input wire ddi_din_type din,
  input wire ddi_drive_type drv,
  // Decoded commands
  output logic [2:0] preset_index,
  output logic [FREQ_W-1:0] motpot_ref,
  output logic ramp_set2,
  output logic ramp_freeze,
  output logic dc_brake_on,
  output ddi_ref_type ref_route,
  output logic [FREQ_W-1:0] ref_const,
  output logic [FREQ_W-1:0] freq_max,
  output ddi_place_type ctrl_place,
  output logic place_forced,
  output logic parameter_bank_select,
  output logic control_mode_select,
  output logic master_follower_alt_in,
  output logic inch_start,
  // Faults and monitoring
  output logic ext_fault,
  output logic brake_feedback_fault,
  output logic [7:0] fault_code,
  output logic [15:0] shaft_angle,
  output logic [15:0] shaft_rounds
);
  if (FREQ_W < 8 || FREQ_W > 16 || MP_STEP < 1 || ANGLE_COUNT < 2 || ANGLE_COUNT > 65536) begin
    $error("ddi_top: unsupported parameter value");
  end

  function automatic logic rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // Registered samples of every function input
  ddi_din_type s_reg, p_reg;
  ddi_drive_type d_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // Idle contacts, so a closed fault loop does not read as open after reset
      s_reg <= DIN_IDLE;
      p_reg <= DIN_IDLE;
      d_reg <= '0;
    end else begin
      s_reg <= din;
      p_reg <= s_reg;
      d_reg <= drv;
    end
  end

  // Software registers
  logic [31:0] ctrl_reg, ctrl_next, jog_reg, jog_next, inch_reg, inch_next;
  logic [31:0] lim_reg, lim_next, btime_reg, btime_next, rdata_reg, rdata_next;
  logic decel_during_hold_option;
  logic [4:0] ref_src_code;
  ddi_place_type stored_place;
  assign decel_during_hold_option = ctrl_reg[CTRL_DECEL_BIT];
  assign ref_src_code = ctrl_reg[CTRL_SRC_LSB +: 5];
  assign stored_place = ddi_place_type'(ctrl_reg[CTRL_PLACE_LSB +: 2]);

  // Command state
  logic [2:0] pidx_reg, pidx_next;
  logic [FREQ_W-1:0] mp_reg, mp_next, rconst_reg, rconst_next, fmax_reg, fmax_next;
  logic [31:0] mpc_reg, mpc_next;
  logic rs2_reg, rs2_next, frz_reg, frz_next, dcb_reg, dcb_next;
  ddi_ref_type route_reg, route_next;
  ddi_place_type place_reg, place_next;
  logic forced_reg, forced_next, bank_reg, bank_next, mode_reg, mode_next;
  logic mf_reg, mf_next, inch_run_reg, inch_run_next;
  logic extf_reg, extf_next, brkf_reg, brkf_next;
  logic [7:0] fcode_reg, fcode_next;
  ddi_brk_type brk_reg, brk_next;
  logic [31:0] bcnt_reg, bcnt_next;
  logic [15:0] ang_reg, ang_next, rnd_reg, rnd_next;

  logic ext_cond, inch_ok, is_const;
  always_comb begin
    ctrl_next = ctrl_reg;
    jog_next = jog_reg;
    inch_next = inch_reg;
    lim_next = lim_reg;
    btime_next = btime_reg;
    rdata_next = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: ctrl_next = reg_wdata;
        OFS_JOG_REF: jog_next = reg_wdata;
        OFS_INCH_REF: inch_next = reg_wdata;
        OFS_FREQ_LIM: lim_next = reg_wdata;
        OFS_BRAKE_TIME: btime_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rdata_next = ctrl_reg;
        OFS_JOG_REF: rdata_next = jog_reg;
        OFS_INCH_REF: rdata_next = inch_reg;
        OFS_FREQ_LIM: rdata_next = lim_reg;
        OFS_BRAKE_TIME: rdata_next = btime_reg;
        OFS_STATUS: rdata_next = {fcode_reg, 6'h00, route_reg, forced_reg, place_reg,
                                  bank_reg, mode_reg, mf_reg, inch_run_reg, extf_reg,
                                  brkf_reg, frz_reg, dcb_reg, rs2_reg, pidx_reg};
        OFS_SHAFT: rdata_next = {rnd_reg, ang_reg};
        OFS_MOTPOT: rdata_next = 32'(mp_reg);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    pidx_next = s_reg.preset;
    // Pot steps at a fixed rate; both inputs closed cancel each other
    mp_next = mp_reg;
    mpc_next = 32'h0000_0000;
    if (s_reg.mp_up ^ s_reg.mp_down) begin
      mpc_next = mpc_reg + 32'h0000_0001;
      if (mpc_reg >= 32'(MP_STEP - 1)) begin
        mpc_next = 32'h0000_0000;
        if (s_reg.mp_up && mp_reg != '1) mp_next = mp_reg + 1'b1;
        if (s_reg.mp_down && mp_reg != '0) mp_next = mp_reg - 1'b1;
      end
    end
    rs2_next = s_reg.ramp_sel;
    frz_next = s_reg.ramp_hold &&
               !(decel_during_hold_option && d_reg.ref_below_speed);
    dcb_next = s_reg.dc_braking_in && !d_reg.running;
    // Inching first, then jog, then the selectable sources
    inch_ok = s_reg.inch_enable && !d_reg.start_active;
    inch_run_next = inch_ok && (s_reg.inch1 || s_reg.inch2) && !d_reg.other_run_req;
    rconst_next = '0;
    if (inch_ok && s_reg.inch1) begin
      route_next = REF_INCH1;
      rconst_next = inch_reg[FREQ_W-1:0];
    end else if (inch_ok && s_reg.inch2) begin
      route_next = REF_INCH2;
      rconst_next = inch_reg[16 +: FREQ_W];
    end else if (s_reg.jog) begin
      route_next = REF_JOG;
      rconst_next = jog_reg[FREQ_W-1:0];
    end else if (ref_src_code == SRC_AI_SEL) begin
      route_next = s_reg.ref_select ? REF_AI2 : REF_AI1;
    end else begin
      route_next = s_reg.ref_select ? REF_SRC2 : REF_SRC1;
    end
    // Jog and preset references bypass the second limit; inching references do not
    is_const = s_reg.jog || s_reg.preset != 3'b000;
    fmax_next = (s_reg.second_limit && !is_const) ? lim_reg[16 +: FREQ_W]
                                                  : lim_reg[FREQ_W-1:0];
    // Stored place lives in the control register and is never written here
    forced_next = s_reg.force_io || s_reg.force_fieldbus || s_reg.force_keypad;
    if (s_reg.force_io) place_next = PLACE_IO;
    else if (s_reg.force_fieldbus) place_next = PLACE_FIELDBUS;
    else if (s_reg.force_keypad) place_next = PLACE_KEYPAD;
    else place_next = stored_place;
    bank_next = d_reg.running ? bank_reg : s_reg.parameter_bank_select;
    mode_next = s_reg.control_mode_select;
    mf_next = s_reg.master_follower_alt_in;
    // Brake supervision
    brk_next = brk_reg;
    bcnt_next = bcnt_reg;
    case (brk_reg)
      BRK_IDLE: begin
        bcnt_next = 32'h0000_0000;
        if (d_reg.brake_open_cmd && !s_reg.brake_ack) brk_next = BRK_WAIT;
      end
      BRK_WAIT: begin
        bcnt_next = bcnt_reg + 32'h0000_0001;
        if (!d_reg.brake_open_cmd || s_reg.brake_ack) brk_next = BRK_IDLE;
        else if (bcnt_reg >= btime_reg) brk_next = BRK_DONE;
      end
      BRK_DONE: begin
        if (!d_reg.brake_open_cmd) brk_next = BRK_IDLE;
      end
      default: brk_next = BRK_IDLE;
    endcase
    // Sticky faults: a new fault wins over a clear in the same cycle
    ext_cond = s_reg.ext_fault_no || !s_reg.ext_fault_nc;
    extf_next = extf_reg;
    brkf_next = brkf_reg;
    if (rise(s_reg.fault_clear, p_reg.fault_clear)) begin
      extf_next = 1'b0;
      brkf_next = 1'b0;
    end
    if (ext_cond) extf_next = 1'b1;
    if (brk_reg == BRK_WAIT && brk_next == BRK_DONE) brkf_next = 1'b1;
    if (extf_next) fcode_next = FAULT_EXT;
    else if (brkf_next) fcode_next = FAULT_BRAKE;
    else fcode_next = FAULT_NONE;
    // Shaft monitor; reset edge beats a step in the same cycle
    ang_next = ang_reg;
    rnd_next = rnd_reg;
    if (rise(s_reg.pos_reset, p_reg.pos_reset)) begin
      ang_next = 16'h0000;
      rnd_next = 16'h0000;
    end else if (d_reg.enc_step) begin
      if (32'(ang_reg) >= ANGLE_COUNT - 1) begin
        ang_next = 16'h0000;
        rnd_next = rnd_reg + 16'h0001;
      end else begin
        ang_next = ang_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      jog_reg <= 32'h0000_0000;
      inch_reg <= 32'h0000_0000;
      lim_reg <= 32'h0000_0000;
      btime_reg <= BRAKE_TIME_RESET;
      rdata_reg <= 32'h0000_0000;
      pidx_reg <= 3'h0;
      mp_reg <= '0;
      mpc_reg <= 32'h0000_0000;
      rs2_reg <= 1'b0;
      frz_reg <= 1'b0;
      dcb_reg <= 1'b0;
      route_reg <= REF_SRC1;
      rconst_reg <= '0;
      fmax_reg <= '0;
      place_reg <= PLACE_IO;
      forced_reg <= 1'b0;
      bank_reg <= 1'b0;
      mode_reg <= 1'b0;
      mf_reg <= 1'b0;
      inch_run_reg <= 1'b0;
      extf_reg <= 1'b0;
      brkf_reg <= 1'b0;
      fcode_reg <= FAULT_NONE;
      brk_reg <= BRK_IDLE;
      bcnt_reg <= 32'h0000_0000;
      ang_reg <= 16'h0000;
      rnd_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      jog_reg <= jog_next;
      inch_reg <= inch_next;
      lim_reg <= lim_next;
      btime_reg <= btime_next;
      rdata_reg <= rdata_next;
      pidx_reg <= pidx_next;
      mp_reg <= mp_next;
      mpc_reg <= mpc_next;
      rs2_reg <= rs2_next;
      frz_reg <= frz_next;
      dcb_reg <= dcb_next;
      route_reg <= route_next;
      rconst_reg <= rconst_next;
      fmax_reg <= fmax_next;
      place_reg <= place_next;
      forced_reg <= forced_next;
      bank_reg <= bank_next;
      mode_reg <= mode_next;
      mf_reg <= mf_next;
      inch_run_reg <= inch_run_next;
      extf_reg <= extf_next;
      brkf_reg <= brkf_next;
      fcode_reg <= fcode_next;
      brk_reg <= brk_next;
      bcnt_reg <= bcnt_next;
      ang_reg <= ang_next;
      rnd_reg <= rnd_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign preset_index = pidx_reg;
  assign motpot_ref = mp_reg;
  assign ramp_set2 = rs2_reg;
  assign ramp_freeze = frz_reg;
  assign dc_brake_on = dcb_reg;
  assign ref_route = route_reg;
  assign ref_const = rconst_reg;
  assign freq_max = fmax_reg;
  assign ctrl_place = place_reg;
  assign place_forced = forced_reg;
  assign parameter_bank_select = bank_reg;
  assign control_mode_select = mode_reg;
  assign master_follower_alt_in = mf_reg;
  assign inch_start = inch_run_reg;
  assign ext_fault = extf_reg;
  assign brake_feedback_fault = brkf_reg;
  assign fault_code = fcode_reg;
  assign shaft_angle = ang_reg;
  assign shaft_rounds = rnd_reg;

  // Checks
  a_preset_index_map: assert property (@(posedge clk_sys) disable iff (!resetn)
    1'b1 |=> preset_index == $past(s_reg.preset)) else $error("preset index mismatch");
  a_pot_up_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.mp_up && !s_reg.mp_down && mp_reg != '1 && mpc_reg == 32'(MP_STEP - 1)
    |=> motpot_ref == $past(mp_reg) + 1'b1) else $error("pot did not step up");
  a_pot_down_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.mp_down && !s_reg.mp_up && mp_reg != '0 && mpc_reg == 32'(MP_STEP - 1)
    |=> motpot_ref == $past(mp_reg) - 1'b1) else $error("pot did not step down");
  a_fault_clear_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.fault_clear && p_reg.fault_clear && !ext_cond && brk_reg != BRK_WAIT
    |=> ext_fault == $past(extf_reg)) else $error("level cleared a fault");
  a_ext_fault_set: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_reg.ext_fault_no || !s_reg.ext_fault_nc) |=> ext_fault && fault_code == FAULT_EXT)
    else $error("external fault not raised");
  a_ramp_hold_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.ramp_hold && !(decel_during_hold_option && d_reg.ref_below_speed) |=> ramp_freeze)
    else $error("hold did not freeze ramp");
  a_dc_brake_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
    d_reg.running |=> !dc_brake_on) else $error("dc braking while running");
  a_force_priority: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.force_io |=> ctrl_place == PLACE_IO && place_forced)
    else $error("terminal force lost priority");
  a_bank_frozen_run: assert property (@(posedge clk_sys) disable iff (!resetn)
    d_reg.running |=> $stable(parameter_bank_select)) else $error("bank changed in run");
  a_brake_fault_time: assert property (@(posedge clk_sys) disable iff (!resetn)
    brk_reg == BRK_WAIT && d_reg.brake_open_cmd && !s_reg.brake_ack && bcnt_reg >= btime_reg
    |=> brake_feedback_fault) else $error("brake fault missed");
  a_fault_code_map: assert property (@(posedge clk_sys) disable iff (!resetn)
    brake_feedback_fault && !ext_fault |-> fault_code == FAULT_BRAKE) else $error("bad fault code");
  a_inch_blocked: assert property (@(posedge clk_sys) disable iff (!resetn)
    d_reg.start_active || !s_reg.inch_enable |=> !inch_start) else $error("inching not blocked");
  a_pos_reset_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_reg.pos_reset && !p_reg.pos_reset |=> shaft_angle == 16'h0000 && shaft_rounds == 16'h0000)
    else $error("shaft monitor not cleared");

  c_inch_start: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(inch_start));
  c_brake_fault: cover property (@(posedge clk_sys) disable iff (!resetn)
    $rose(brake_feedback_fault));
  c_fault_cleared: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(ext_fault));
  c_forced_keypad: cover property (@(posedge clk_sys) disable iff (!resetn)
    place_forced && ctrl_place == PLACE_KEYPAD);
endmodule // ddi_top

/* tb/ddi_contacts.sv */
`timescale 1ns/1ps
// Contacts and PLC bits; one register stage stands for the wiring delay,
// so the bench never leans on zero-delay inputs.
module ddi_contacts
  import ddi_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Wanted contact states and the levels seen by the drive
  input wire ddi_din_type want,
  output ddi_din_type din
);
  always @(posedge clk_sys) begin
    din <= want;
  end
endmodule // ddi_contacts

/* tb/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module tb;
  import ddi_pkg::*;
  localparam int MPS = 4;
  localparam int ANG = 8;
  logic clk_sys;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  ddi_din_type want;
  ddi_din_type din;
  ddi_drive_type drv;
  logic [2:0] preset_index;
  logic [15:0] motpot_ref, ref_const, freq_max, shaft_angle, shaft_rounds;
  logic ramp_set2, ramp_freeze, dc_brake_on, place_forced, parameter_bank_select;
  logic control_mode_select, master_follower_alt_in, inch_start, ext_fault;
  logic brake_feedback_fault;
  ddi_ref_type ref_route;
  ddi_place_type ctrl_place;
  logic [7:0] fault_code;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [15:0] v;
  logic [2:0] fv [7] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b111, 3'b011, 3'b000};
  logic [1:0] pe [7] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h2, 2'h1};

  ddi_contacts ddi_contacts_i (.clk_sys(clk_sys), .want(want), .din(din));
  ddi_top #(.MP_STEP(MPS), .ANGLE_COUNT(ANG)) ddi_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .din(din), .drv(drv),
    .preset_index(preset_index), .motpot_ref(motpot_ref), .ramp_set2(ramp_set2),
    .ramp_freeze(ramp_freeze), .dc_brake_on(dc_brake_on), .ref_route(ref_route),
    .ref_const(ref_const), .freq_max(freq_max), .ctrl_place(ctrl_place),
    .place_forced(place_forced), .parameter_bank_select(parameter_bank_select),
    .control_mode_select(control_mode_select),
    .master_follower_alt_in(master_follower_alt_in), .inch_start(inch_start),
    .ext_fault(ext_fault), .brake_feedback_fault(brake_feedback_fault),
    .fault_code(fault_code), .shaft_angle(shaft_angle), .shaft_rounds(shaft_rounds));

  // Contact stage plus input sample plus output register
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic clr();
    @(posedge clk_sys);
    want.fault_clear <= 1'b1;
    settle();
    @(posedge clk_sys);
    want.fault_clear <= 1'b0;
    settle();
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    want = '0;
    want.ext_fault_nc = 1'b1;
    drv = '0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_CTRL);
    `CHK("ctrl rst", CTRL_RESET, d)
    rd(OFS_BRAKE_TIME);
    `CHK("brake time rst", BRAKE_TIME_RESET, d)
    rd(8'h20);
    `CHK("unmapped", 32'h0, d)
    wr(OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS);
    `CHK("status ro", 32'h0, d)
    $display("test regs done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      want.preset <= 3'(i);
      settle();
      `CHK("preset", 3'(i), preset_index)
    end
    rd(OFS_STATUS);
    `CHK("status preset", 3'h7, d[2:0])
    @(posedge clk_sys);
    want.preset <= 3'h0;
    want.mp_up <= 1'b1;
    repeat (10 * MPS) @(posedge clk_sys);
    want.mp_up <= 1'b0;
    settle();
    v = motpot_ref;
    `CHK("pot up", 1'b1, v > 16'h0)
    repeat (5 * MPS) @(posedge clk_sys);
    #1;
    `CHK("pot stop", v, motpot_ref)
    @(posedge clk_sys);
    want.mp_down <= 1'b1;
    repeat (4 * MPS) @(posedge clk_sys);
    want.mp_down <= 1'b0;
    settle();
    `CHK("pot down", 1'b1, motpot_ref < v && motpot_ref > 16'h0)
    $display("test preset and pot done");
    @(posedge clk_sys);
    want.ext_fault_no <= 1'b1;
    settle();
    `CHK("ext no", 1'b1, ext_fault)
    `CHK("ext code", FAULT_EXT, fault_code)
    @(posedge clk_sys);
    want.ext_fault_no <= 1'b0;
    settle();
    `CHK("ext sticky", 1'b1, ext_fault)
    clr();
    `CHK("ext clr", FAULT_NONE, fault_code)
    @(posedge clk_sys);
    want.ext_fault_nc <= 1'b0;
    want.fault_clear <= 1'b1;
    settle();
    `CHK("ext nc", 1'b1, ext_fault)
    @(posedge clk_sys);
    want.ext_fault_nc <= 1'b1;
    settle();
    `CHK("clr level", 1'b1, ext_fault)
    @(posedge clk_sys);
    want.fault_clear <= 1'b0;
    settle();
    clr();
    `CHK("clr edge", 1'b0, ext_fault)
    $display("test ext fault done");
    @(posedge clk_sys);
    want.ramp_sel <= 1'b1;
    want.ramp_hold <= 1'b1;
    want.dc_braking_in <= 1'b1;
    settle();
    `CHK("ramp set2", 1'b1, ramp_set2)
    `CHK("hold", 1'b1, ramp_freeze)
    `CHK("dc stop", 1'b1, dc_brake_on)
    wr(OFS_CTRL, 32'h1);
    @(posedge clk_sys);
    drv.ref_below_speed <= 1'b1;
    drv.running <= 1'b1;
    settle();
    `CHK("hold decel", 1'b0, ramp_freeze)
    `CHK("dc run", 1'b0, dc_brake_on)
    @(posedge clk_sys);
    want.ramp_sel <= 1'b0;
    want.ramp_hold <= 1'b0;
    want.dc_braking_in <= 1'b0;
    drv.ref_below_speed <= 1'b0;
    drv.running <= 1'b0;
    settle();
    `CHK("ramp set1", 1'b0, ramp_set2)
    `CHK("unhold", 1'b0, ramp_freeze)
    $display("test ramp and dc done");
    @(posedge clk_sys);
    want.parameter_bank_select <= 1'b1;
    want.control_mode_select <= 1'b1;
    want.master_follower_alt_in <= 1'b1;
    settle();
    `CHK("bank", 1'b1, parameter_bank_select)
    `CHK("mode2", 1'b1, control_mode_select)
    `CHK("mf2", 1'b1, master_follower_alt_in)
    @(posedge clk_sys);
    drv.running <= 1'b1;
    want.parameter_bank_select <= 1'b0;
    want.control_mode_select <= 1'b0;
    want.master_follower_alt_in <= 1'b0;
    settle();
    `CHK("bank run", 1'b1, parameter_bank_select)
    `CHK("mode1", 1'b0, control_mode_select)
    `CHK("mf1", 1'b0, master_follower_alt_in)
    @(posedge clk_sys);
    drv.running <= 1'b0;
    settle();
    `CHK("bank stop", 1'b0, parameter_bank_select)
    $display("test selects done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, i[1] ? 32'h0 : 32'h0e00);
      @(posedge clk_sys);
      want.ref_select <= i[0];
      settle();
      `CHK("route", 3'(i[1] ? i[0] : 2 + i[0]), ref_route)
    end
    wr(OFS_JOG_REF, 32'h1234);
    wr(OFS_FREQ_LIM, 32'h0100_0800);
    @(posedge clk_sys);
    want.jog <= 1'b1;
    want.second_limit <= 1'b1;
    settle();
    `CHK("jog route", REF_JOG, ref_route)
    `CHK("jog ref", 16'h1234, ref_const)
    `CHK("lim const", 16'h0800, freq_max)
    @(posedge clk_sys);
    want.jog <= 1'b0;
    settle();
    `CHK("lim2", 16'h0100, freq_max)
    @(posedge clk_sys);
    want.second_limit <= 1'b0;
    settle();
    `CHK("lim1", 16'h0800, freq_max)
    $display("test reference done");
    wr(OFS_INCH_REF, 32'h0002_0001);
    @(posedge clk_sys);
    want.inch_enable <= 1'b1;
    want.inch1 <= 1'b1;
    settle();
    `CHK("inch1", 1'b1, inch_start)
    `CHK("inch1 ref", 16'h1, ref_const)
    @(posedge clk_sys);
    want.inch1 <= 1'b0;
    want.inch2 <= 1'b1;
    settle();
    `CHK("inch2 route", REF_INCH2, ref_route)
    `CHK("inch2 ref", 16'h2, ref_const)
    @(posedge clk_sys);
    drv.start_active <= 1'b1;
    settle();
    `CHK("inch start blk", 1'b0, inch_start)
    @(posedge clk_sys);
    drv.start_active <= 1'b0;
    drv.other_run_req <= 1'b1;
    settle();
    `CHK("inch run blk", 1'b0, inch_start)
    @(posedge clk_sys);
    drv.other_run_req <= 1'b0;
    want.inch_enable <= 1'b0;
    settle();
    `CHK("inch dis", 1'b0, inch_start)
    @(posedge clk_sys);
    want.inch2 <= 1'b0;
    $display("test inching done");
    wr(OFS_CTRL, 32'h10);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      {want.force_io, want.force_keypad, want.force_fieldbus} <= fv[i];
      settle();
      `CHK("place", pe[i], ctrl_place)
      `CHK("forced", |fv[i], place_forced)
      rd(OFS_CTRL);
      `CHK("stored place", 32'h10, d)
    end
    $display("test place done");
    wr(OFS_BRAKE_TIME, 32'd10);
    @(posedge clk_sys);
    drv.brake_open_cmd <= 1'b1;
    settle();
    `CHK("brake early", 1'b0, brake_feedback_fault)
    repeat (20) @(posedge clk_sys);
    #1;
    `CHK("brake flt", 1'b1, brake_feedback_fault)
    `CHK("brake code", FAULT_BRAKE, fault_code)
    @(posedge clk_sys);
    drv.brake_open_cmd <= 1'b0;
    want.brake_ack <= 1'b1;
    clr();
    `CHK("brake clr", 1'b0, brake_feedback_fault)
    @(posedge clk_sys);
    drv.brake_open_cmd <= 1'b1;
    repeat (30) @(posedge clk_sys);
    #1;
    `CHK("brake ack", 1'b0, brake_feedback_fault)
    @(posedge clk_sys);
    drv.brake_open_cmd <= 1'b0;
    want.brake_ack <= 1'b0;
    $display("test brake done");
    for (int i = 0; i < 13; i++) begin
      if (i == 10) begin
        @(posedge clk_sys);
        #1;
        `CHK("angle", 16'(10 % ANG), shaft_angle)
        `CHK("rounds", 16'(10 / ANG), shaft_rounds)
        want.pos_reset <= 1'b1;
        settle();
        `CHK("pos rst", 32'h0, {shaft_rounds, shaft_angle})
      end
      @(posedge clk_sys);
      drv.enc_step <= 1'b1;
      @(posedge clk_sys);
      drv.enc_step <= 1'b0;
    end
    settle();
    // Held reset input must not keep clearing the count
    `CHK("pos level", 16'h3, shaft_angle)
    $display("test encoder done");
    print_verdict();
  end
endmodule // tb
